/* File: rsp_pkg.sv */
// shared constants for the radar sensor serial link
//
// Summary of operation
// - sensor is slave only; own select, no chaining
// - link carries configuration in, measurement data out
// - master lowers select before first clock edge
// - sensor samples mosi on rising clock edge
// - sensor changes miso only on falling edges; the code also stages the first msb on miso as select goes low
// - master releases select between transactions
// - master clock at most 50 MHz
// - reference clock at most 80 MHz external; the bench clocks the sensor at 100 MHz (CLK_MHZ)
package rsp_pkg;
    localparam int          WORD_W       = 8;
    localparam int          FIFO_DEPTH   = 32;
    localparam int          CLK_MHZ      = 100;
    // link clock limits, in MHz as printed
    localparam int          SCLK_MAX_MHZ = 50;
    localparam int          REFCLK_MAX_MHZ = 80;
    // master half period in mclk cycles; fastest rate rounds down, min 1
    localparam int          HALF_MIN_CYC = (CLK_MHZ / (2 * SCLK_MAX_MHZ)) < 1 ? 1
                                           : (CLK_MHZ / (2 * SCLK_MAX_MHZ));
    localparam int          HALF_CYC     = 8;
    localparam logic [7:0]  IDLE_FILL    = 8'hff;
endpackage : rsp_pkg

/* File: rsp_if.sv */
// serial link wires between the host master and the sensor slave
interface rsp_if;
    logic sclk;
    logic ss_n;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic miso;
    // pulled high when nobody drives
    assign miso = miso_oe_n ? 1'b1 : miso_o;

    modport host (output sclk, output ss_n, output mosi, input miso);
    modport sensor (input sclk, input ss_n, input mosi, output miso_o, output miso_oe_n);
endinterface : rsp_if

/* File: rsp_fifo.sv */
// parameterised first-in first-out buffer with valid/ready on both sides
module rsp_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // write side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // read side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int          AW   = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    logic [W-1:0]  mem [D];
    logic [AW:0]   cnt_q, cnt_d;
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic          wr, rd, rdy_q, rdy_d;

    // ready is kept in a flop so the write side never sees a compare path
    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_comb begin
        wp_d  = wr ? ((wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1) : wp_q;
        rp_d  = rd ? ((rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
        rdy_d = (cnt_d != FULL);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= '0;
            wp_q  <= '0;
            rp_q  <= '0;
            rdy_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (wr) begin
            mem[wp_q] <= in_data;
        end
    end
endmodule : rsp_fifo

/* File: rsp_sensor.sv */
// sensor end: mode 0 spi slave with buffered readout stream
module rsp_sensor
    import rsp_pkg::*;
#(
    parameter int W     = rsp_pkg::WORD_W,
    parameter int DEPTH = rsp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // link
    rsp_if.sensor             link,
    // measurement data to send
    input  wire logic         tx_valid,
    output logic              tx_ready,
    input  wire logic [W-1:0] tx_data,
    // configuration received; active follows select
    output logic              rx_valid,
    output logic      [W-1:0] rx_data,
    output logic              active
);
    import rsp_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sclk_s_q, ss_s_q, mosi_s_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_s_q <= '0;
            ss_s_q   <= 3'h7;
            mosi_s_q <= '0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], link.sclk};
            ss_s_q   <= {ss_s_q[1:0], link.ss_n};
            mosi_s_q <= {mosi_s_q[1:0], link.mosi};
        end
    end
    // a change counts once stages two and three agree
    logic sclk_f_q, ss_f_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_f_q <= 1'b0;
            ss_f_q   <= 1'b1;
        end else begin
            if (sclk_s_q[1] == sclk_s_q[2]) sclk_f_q <= sclk_s_q[2];
            if (ss_s_q[1] == ss_s_q[2]) ss_f_q <= ss_s_q[2];
        end
    end
    logic sclk_now, rise, fall, sel;
    assign sclk_now = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_f_q;
    assign sel      = !ss_f_q;
    assign rise     = sel && !sclk_f_q && sclk_now;
    assign fall     = sel && sclk_f_q && !sclk_now;

    // ----------------------------------------------------------------
    // readout buffer
    // ----------------------------------------------------------------
    logic         f_valid, f_ready;
    logic [W-1:0] f_data;
    rsp_fifo #(.W(W), .D(DEPTH)) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // ----------------------------------------------------------------
    // shifter
    // ----------------------------------------------------------------
    localparam int CW = $clog2(W);
    logic [W-1:0]  rxs_q, rxs_d, txs_q, txs_d, rxd_q, rxd_d;
    logic [CW-1:0] bit_q, bit_d;
    logic          miso_q, miso_d, oen_q, oen_d, rxv_q, rxv_d, first_q, first_d;
    logic          held_q, held_d, pop;

    always_comb begin
        rxs_d   = rxs_q;
        txs_d   = txs_q;
        rxd_d   = rxd_q;
        bit_d   = bit_q;
        miso_d  = miso_q;
        rxv_d   = 1'b0;
        first_d = first_q;
        held_d  = held_q;
        pop     = 1'b0;
        oen_d   = !sel;
        if (!sel) begin
            // select release ends the transaction
            bit_d   = '0;
            first_d = 1'b1;
        end else begin
            if (rise) begin
                rxs_d = {rxs_q[W-2:0], mosi_s_q[2]};
                bit_d = bit_q + 1'b1;
                // a staged word leaves the buffer only once its first bit is clocked,
                // so a word staged just before select release is offered again
                if (bit_q == '0) begin
                    pop = held_q;
                end
                if (bit_q == CW'(W - 1)) begin
                    rxd_d = {rxs_q[W-2:0], mosi_s_q[2]};
                    rxv_d = 1'b1;
                    bit_d = '0;
                end
            end
            if (first_q || (fall && bit_q == '0)) begin
                // stage the next word: its msb must stand before its first rising edge
                txs_d   = f_valid ? f_data : IDLE_FILL;
                held_d  = f_valid;
                miso_d  = txs_d[W-1];
                first_d = 1'b0;
            end else if (fall) begin
                txs_d  = {txs_q[W-2:0], 1'b0};
                miso_d = txs_q[W-2];
            end
        end
    end
    assign f_ready = pop;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rxs_q   <= '0;
            txs_q   <= '0;
            rxd_q   <= '0;
            bit_q   <= '0;
            miso_q  <= 1'b1;
            oen_q   <= 1'b1;
            rxv_q   <= 1'b0;
            first_q <= 1'b1;
            held_q  <= 1'b0;
        end else begin
            rxs_q   <= rxs_d;
            txs_q   <= txs_d;
            rxd_q   <= rxd_d;
            bit_q   <= bit_d;
            miso_q  <= miso_d;
            oen_q   <= oen_d;
            rxv_q   <= rxv_d;
            first_q <= first_d;
            held_q  <= held_d;
        end
    end

    logic act_q;
    always_ff @(posedge mclk) begin
        if (rst) act_q <= 1'b0;
        else     act_q <= sel;
    end

    // slave only: no chained output path exists
    assign link.miso_o    = miso_q;
    assign link.miso_oe_n = oen_q;
    assign rx_valid       = rxv_q;
    assign rx_data        = rxd_q;
    assign active         = act_q;
endmodule : rsp_sensor

/* File: rsp_host.sv */
// host end: mode 0 spi master sending one word per transaction
module rsp_host
    import rsp_pkg::*;
#(
    parameter int W    = rsp_pkg::WORD_W,
    parameter int HALF = rsp_pkg::HALF_CYC
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // link
    rsp_if.host               link,
    // request
    input  wire logic         req_valid,
    output logic              req_ready,
    input  wire logic [W-1:0] req_data,
    // answer
    output logic              rsp_valid,
    output logic      [W-1:0] rsp_data
);
    import rsp_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_HOLD, S_GAP} rsp_st_e;

    // half period never below the 50 MHz limit
    localparam int HP = (HALF < HALF_MIN_CYC) ? HALF_MIN_CYC : HALF;

    logic [2:0] miso_s_q;
    logic       miso_f_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            miso_s_q <= 3'h7;
            miso_f_q <= 1'b1;
        end else begin
            miso_s_q <= {miso_s_q[1:0], link.miso};
            // a change counts only once stages two and three agree
            if (miso_s_q[1] == miso_s_q[2]) miso_f_q <= miso_s_q[2];
        end
    end

    rsp_st_e    st_q, st_d;
    logic [15:0] div_q, div_d;
    logic [W-1:0] sh_q, sh_d, rx_q, rx_d;
    logic [7:0]  n_q, n_d;
    logic        sclk_q, sclk_d, ss_q, ss_d, mosi_q, mosi_d, rv_q, rv_d, rdy_q, rdy_d;
    logic        tick;
    assign tick = (div_q == 16'(HP - 1));

    always_comb begin
        st_d   = st_q;
        div_d  = tick ? '0 : div_q + 1'b1;
        sh_d   = sh_q;
        rx_d   = rx_q;
        n_d    = n_q;
        sclk_d = sclk_q;
        ss_d   = ss_q;
        mosi_d = mosi_q;
        rv_d   = 1'b0;
        rdy_d  = 1'b0;
        unique case (st_q)
            S_IDLE: begin
                div_d = '0;
                rdy_d = 1'b1;
                if (req_valid && rdy_q) begin
                    rdy_d  = 1'b0;
                    ss_d   = 1'b0;
                    sh_d   = req_data;
                    mosi_d = req_data[W-1];
                    n_d    = '0;
                    st_d   = S_SETUP;
                end
            end
            S_SETUP: if (tick) begin
                sclk_d = 1'b1;
                st_d   = S_HIGH;
            end
            S_HIGH: if (tick) begin
                // sample late in the high phase, past the sensor's sync delay
                rx_d   = {rx_q[W-2:0], miso_f_q};
                sclk_d = 1'b0;
                n_d    = n_q + 1'b1;
                sh_d   = {sh_q[W-2:0], 1'b0};
                mosi_d = sh_q[W-2];
                st_d   = (n_q == 8'(W - 1)) ? S_HOLD : S_LOW;
            end
            S_LOW: if (tick) begin
                sclk_d = 1'b1;
                st_d   = S_HIGH;
            end
            S_HOLD: if (tick) begin
                ss_d = 1'b1;
                rv_d = 1'b1;
                st_d = S_GAP;
            end
            S_GAP: if (tick) begin
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q   <= S_IDLE;
            div_q  <= '0;
            sh_q   <= '0;
            rx_q   <= '0;
            n_q    <= '0;
            sclk_q <= 1'b0;
            ss_q   <= 1'b1;
            mosi_q <= 1'b0;
            rv_q   <= 1'b0;
            rdy_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            sh_q   <= sh_d;
            rx_q   <= rx_d;
            n_q    <= n_d;
            sclk_q <= sclk_d;
            ss_q   <= ss_d;
            mosi_q <= mosi_d;
            rv_q   <= rv_d;
            rdy_q  <= rdy_d;
        end
    end

    assign link.sclk = sclk_q;
    assign link.ss_n = ss_q;
    assign link.mosi = mosi_q;
    assign req_ready = rdy_q;
    assign rsp_valid = rv_q;
    assign rsp_data  = rx_q;
endmodule : rsp_host

/* File: rsp_monitor.sv */
// concurrent checks on the serial link between host and sensor
module rsp_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    // ------------------------------------------------------------
    // rising edges seen in the current frame
    // ------------------------------------------------------------
    logic       sclk_q, sclk_d;
    logic [3:0] cnt_q, cnt_d;

    always_comb begin
        sclk_d = sclk;
        cnt_d  = ss_n ? 4'h0 : cnt_q + {3'h0, sclk & ~sclk_q};
    end

    always_ff @(posedge mclk) begin
        sclk_q <= rst ? 1'b0 : sclk_d;
        cnt_q  <= rst ? 4'h0 : cnt_d;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_high;
        sclk [*8] ##1 !sclk;
    endsequence
    sequence s_gap;
        ss_n [*8] ##1 ss_n;
    endsequence

    chk_reset_idle: assert property (disable iff (1'b0) rst |=> ss_n && !sclk && miso_oe_n)
        else $error("link not idle after reset");
    chk_sclk_idle_low: assert property (ss_n |-> !sclk)
        else $error("serial clock high while deselected");
    chk_select_first: assert property ($rose(sclk) |-> !ss_n && !$past(ss_n, 4))
        else $error("clock edge without select setup");
    chk_high_phase: assert property ($rose(sclk) |-> s_high)
        else $error("serial clock high phase not eight cycles");
    chk_release_gap: assert property ($rose(ss_n) |-> s_gap)
        else $error("select gap too short");
    chk_mosi_stable: assert property (sclk |-> $stable(mosi))
        else $error("mosi moved while clock high");
    chk_miso_on_fall: assert property (!ss_n && $changed(miso_o) |-> !sclk && !$past(sclk, 3))
        else $error("miso changed outside low phase");
    chk_deselect_float: assert property (ss_n [*6] |-> miso_oe_n)
        else $error("miso driven while deselected");
    chk_frame_bits: assert property ($rose(ss_n) |-> cnt_q == 4'h8)
        else $error("frame not eight clocks");
endmodule : rsp_monitor

/* File: radar_sensor_spi_slave_bench.sv */
// self-checking bench: host and sensor joined across the serial link
module radar_sensor_spi_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rsp_pkg::*;
    logic              mclk, rst, req_valid, req_ready, rsp_valid;
    logic              tx_valid, tx_ready, rx_valid, active;
    logic [WORD_W-1:0] req_data, rsp_data, tx_data, rx_data;
    logic [15:0]       lfsr_q;
    logic [WORD_W-1:0] q_rx[$], q_rsp[$];
    int                err_total, checks_done, n;

    rsp_if link ();
    rsp_host i_rsp_host (.mclk(mclk), .rst(rst), .link(link), .req_valid(req_valid), .req_ready(req_ready),
        .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    rsp_sensor i_rsp_sensor (.mclk(mclk), .rst(rst), .link(link), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .active(active));
    rsp_monitor i_rsp_monitor (.mclk(mclk), .rst(rst), .sclk(link.sclk), .ss_n(link.ss_n), .mosi(link.mosi),
        .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic compare(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic do_reset();
        rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
    endtask : do_reset

    // called just after an edge; ready is settled then, so the next edge takes the word
    task automatic host_send(input logic [WORD_W-1:0] d);
        req_valid = 1'b1;
        req_data  = d;
        while (req_ready !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        @(posedge mclk);
        #1;
    endtask : host_send

    // lets the queues drain, then checks that the sensor has gone idle
    task automatic finish_test(input string name);
        repeat (400) if (q_rx.size() + q_rsp.size() > 0) @(posedge mclk);
        repeat (8) @(posedge mclk);
        #1;
        compare(8'(q_rx.size() + q_rsp.size()), 8'h00);
        compare({7'h00, active}, 8'h00);
        $display("test %s done, mismatches %0d", name, err_total);
    endtask : finish_test

    initial mclk = 1'b0;
    // the sensor's own clock stands in for its reference clock
    always #5 mclk = ~mclk;

    // results are sampled mid-cycle, well after the launching edge has settled them
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) begin
            if (q_rx.size() > 0) begin
                compare(rx_data, q_rx.pop_front());
            end else begin
                err_total++;
                $display("mismatch at %0t: got %h expected %h, nothing pending", $time, rx_data, 8'h00);
            end
        end
        if (rsp_valid === 1'b1) begin
            if (q_rsp.size() > 0) begin
                compare(rsp_data, q_rsp.pop_front());
            end else begin
                err_total++;
                $display("mismatch at %0t: got %h expected %h, nothing pending", $time, rsp_data, 8'h00);
            end
        end
    end

    initial begin
        #300us;
        err_total++;
        final_report();
    end

    initial begin
        {req_valid, tx_valid, err_total, checks_done, n} = '0;
        {req_data, tx_data} = '0;
        lfsr_q = 16'hcfcf;
        do_reset();
        // ------------------------------------------------------------
        // fill the readout buffer until refused, then drain over the link
        // ------------------------------------------------------------
        tx_valid = 1'b1;
        while (n < 40) begin
            lfsr_q  = lfsr_next(lfsr_q);
            tx_data = lfsr_q[7:0];
            // ready is settled just after the edge; the next edge writes the word
            if (tx_ready !== 1'b1) break;
            q_rsp.push_back(tx_data);
            n++;
            @(posedge mclk);
            #1;
        end
        tx_valid = 1'b0;
        compare(8'(n), 8'(FIFO_DEPTH));
        for (int i = 0; i <= n; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            q_rx.push_back(lfsr_q[7:0]);
            if (i == n) q_rsp.push_back(IDLE_FILL);
            host_send(lfsr_q[7:0]);
        end
        finish_test("fill_drain");
        // ------------------------------------------------------------
        // reset in mid-frame: the partial word must never arrive
        // ------------------------------------------------------------
        host_send(8'ha5);
        repeat (58) @(posedge mclk);
        #1;
        compare({7'h00, active}, 8'h01);
        do_reset();
        q_rx.push_back(8'ha5);
        q_rsp.push_back(IDLE_FILL);
        host_send(8'ha5);
        finish_test("abort");
        final_report();
    end
endmodule : radar_sensor_spi_slave_bench
